// ===== src/phc_pkg.sv
// Register map, field positions and encodings for the holdover and calibration block
package phc_pkg;
  // Register offsets
  localparam logic [9:0] ADDR_LOCK_CAL = 10'h018;
  localparam logic [9:0] ADDR_LD_PIN = 10'h01a;
  localparam logic [9:0] ADDR_REF_SEL = 10'h01c;
  localparam logic [9:0] ADDR_HOLD = 10'h01d;
  localparam logic [9:0] ADDR_STATUS = 10'h01f;
  localparam logic [9:0] ADDR_CH0 = 10'h191;
  localparam logic [9:0] ADDR_CH1 = 10'h194;
  localparam logic [9:0] ADDR_CH2 = 10'h197;
  localparam logic [9:0] ADDR_CH3 = 10'h19a;
  localparam logic [9:0] ADDR_VCO_DIV = 10'h1e0;
  localparam logic [9:0] ADDR_UPDATE = 10'h232;
  // Reset values
  localparam logic [7:0] RST_VALUE = 8'h00;
  // Lock and calibration control fields
  localparam int CAL_START_BIT = 0;
  localparam int CAL_DIV_LSB = 1;
  localparam int DLD_DISABLE_BIT = 3;
  localparam int LD_COUNT_LSB = 5;
  // Lock detect pin control field
  localparam logic [5:0] LD_MODE_CURRENT_SRC = 6'h04;
  // Reference control fields
  localparam int REF_BUF_LSB = 1;
  localparam int REF_PREFER_B_BIT = 3;
  localparam int REF_AUTO_SW_BIT = 4;
  // Holdover control fields
  localparam int HOLD_EN_BIT = 0;
  localparam int HOLD_EXT_BIT = 1;
  localparam int LD_COMP_EN_BIT = 3;
  // Channel divider and update fields
  localparam int CH_IGNORE_SYNC_BIT = 6;
  localparam int UPDATE_BIT = 0;
  // Status bits
  localparam int ST_DLD_BIT = 0;
  localparam int ST_REF_A_LOW_BIT = 1;
  localparam int ST_REF_B_LOW_BIT = 2;
  localparam int ST_VCO_LOW_BIT = 3;
  localparam int ST_HOLD_BIT = 4;
  localparam int ST_CAL_DONE_BIT = 6;
  // Lock detect cycle counts per code
  localparam logic [7:0] LD_COUNT_00 = 8'd5;
  localparam logic [7:0] LD_COUNT_01 = 8'd16;
  localparam logic [7:0] LD_COUNT_10 = 8'd64;
  localparam logic [7:0] LD_COUNT_11 = 8'd255;
  // Calibration length in divided calibration clocks
  localparam int CAL_CYCLES = 4400;
  // Holdover states, Gray along armed, hold, rearm
  typedef enum logic [1:0] {
    HS_ARMED = 2'b00,
    HS_HOLD = 2'b01,
    HS_REARM = 2'b11
  } phc_hold_state_t;
  // Calibration states, Gray along the sequence
  typedef enum logic [2:0] {
    CS_IDLE = 3'b000,
    CS_SYNC = 3'b001,
    CS_RUN = 3'b011,
    CS_RELEASE = 3'b010,
    CS_CLOSE = 3'b110
  } phc_cal_state_t;
endpackage : phc_pkg

// ===== src/phc_cal_if.sv
// Signals between the control top and the calibration sequencer
`timescale 1ns/10ps
interface phc_cal_if;
  logic trigger;
  logic [1:0] div_sel;
  logic pfd_tick;
  logic out_sync;
  logic loop_open;
  logic done;
  modport ctrl (output trigger, output div_sel, output pfd_tick,
    input out_sync, input loop_open, input done);
  modport seq (input trigger, input div_sel, input pfd_tick,
    output out_sync, output loop_open, output done);
endinterface : phc_cal_if

// ===== src/phc_cal_seq.sv
// Calibration sequencer: sync, calibrate, release, close loop
`timescale 1ns/10ps
module phc_cal_seq #(
  parameter int CAL_LEN = phc_pkg::CAL_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Link to control top
  phc_cal_if.seq cal
);
  // Refuse lengths the 16-bit cycle counter cannot serve
  if (CAL_LEN < 2 || CAL_LEN > 65535) begin : g_len_check
    $error("CAL_LEN out of range");
  end

  phc_pkg::phc_cal_state_t state;
  phc_pkg::phc_cal_state_t next_state;
  logic [3:0] div_cnt;
  logic [15:0] cyc_cnt;
  logic [3:0] div_last;
  logic cal_tick;
  logic cal_end;

  // Calibration clock tick every 2, 4, 8 or 16 phase detector cycles
  assign div_last = 4'((16'd2 << cal.div_sel) - 16'd1);
  assign cal_tick = cal.pfd_tick && (div_cnt == div_last);
  assign cal_end = cal_tick && (cyc_cnt == 16'(CAL_LEN - 1));

  // Next state of the sequence
  always_comb begin
    next_state = state;
    unique case (state)
      phc_pkg::CS_IDLE: if (cal.trigger) next_state = phc_pkg::CS_SYNC;
      phc_pkg::CS_SYNC: next_state = phc_pkg::CS_RUN;
      phc_pkg::CS_RUN: if (cal_end) next_state = phc_pkg::CS_RELEASE;
      phc_pkg::CS_RELEASE: next_state = phc_pkg::CS_CLOSE;
      phc_pkg::CS_CLOSE: next_state = phc_pkg::CS_IDLE;
      default: next_state = phc_pkg::CS_IDLE;
    endcase
  end

  // State, divider and cycle counter
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= phc_pkg::CS_IDLE;
      div_cnt <= 4'h0;
      cyc_cnt <= 16'h0000;
    end else begin
      state <= next_state;
      if (state != phc_pkg::CS_RUN) begin
        div_cnt <= 4'h0;
        cyc_cnt <= 16'h0000;
      end else if (cal.pfd_tick) begin
        div_cnt <= cal_tick ? 4'h0 : div_cnt + 4'h1;
        if (cal_tick) cyc_cnt <= cyc_cnt + 16'h0001;
      end
    end
  end

  // Sync, loop and completion outputs
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cal.out_sync <= 1'b0;
      cal.loop_open <= 1'b0;
      cal.done <= 1'b0;
    end else begin
      cal.out_sync <= (next_state == phc_pkg::CS_SYNC) || (next_state == phc_pkg::CS_RUN);
      cal.loop_open <= (next_state != phc_pkg::CS_IDLE);
      if (state == phc_pkg::CS_CLOSE) cal.done <= 1'b1; // set wins over a late trigger
      else if (cal.trigger) cal.done <= 1'b0;
    end
  end

  sequence s_cal_start;
    state == phc_pkg::CS_IDLE && cal.trigger;
  endsequence
  sequence s_cal_synced;
    cal.out_sync && cal.loop_open && !cal.done;
  endsequence
  cal_order_seq_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_cal_start |=> s_cal_synced ##1 s_cal_synced)
    else $error("calibration did not start with outputs synced");
  cal_done_late_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(cal.done) |-> !cal.out_sync && !cal.loop_open && !$past(cal.out_sync))
    else $error("calibration done before sync release and loop close");
  cal_length_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(cal.out_sync) |-> $past(cyc_cnt) == 16'(CAL_LEN - 1))
    else $error("calibration length wrong");
endmodule : phc_cal_seq

// ===== src/phc_ctrl.sv
// Holdover control, lock detect, reference selection and register file
`timescale 1ns/10ps
// How it works
// - Holdover enable bit gates both holdover modes
// - Sync pin falling edge tri-states charge pump
// - Exit only on reference edge after sync high
// - Exit pulses B counter reset, prescaler untouched
// - Per-channel ignore-sync bit keeps outputs running; calibration still stops them
// - Automatic mode tri-states on sensed lock loss
// - Comparator off means pin sensed high
// - Automatic holdover ends on reference edge
// - No re-entry until sensed pin high again
// - Holdover follows the selected reference only
// - Lock counter code sets consecutive cycles
// - Disable bit zero enables digital lock
// - Code 000100b selects current-source pin mode
// - External bit zero selects automatic holdover
// - Switchover, preference and buffer enable fields
// - Three low-frequency monitor flags in status
// - Status bit reads one after calibration
// - Sync, calibrate, release, then close loop
// - Calibration clock is phase detector divided
// - Calibration lasts 4400 divided clocks
module phc_ctrl #(
  parameter int NUM_CH = 4,
  parameter int CAL_LEN = phc_pkg::CAL_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port from the serial control port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [9:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Pins and phase detector events
  input wire logic sync_n_i,
  input wire logic lock_detect_pin_i,
  input wire logic ref_input_a_edge_i,
  input wire logic ref_input_b_edge_i,
  input wire logic phase_detector_tick_i,
  input wire logic phase_detector_in_window_i,
  // Frequency monitor comparators
  input wire logic ref_input_a_low_i,
  input wire logic ref_input_b_low_i,
  input wire logic vco_low_i,
  input wire logic clk_input_low_i,
  input wire logic clk_input_sel_i,
  // Analog side controls
  output logic charge_pump_out_tristate_o,
  output logic b_counter_reset_o,
  output logic digital_lock_indicator_o,
  output logic current_source_lock_indicator_o,
  output logic ref_use_b_o,
  output logic [1:0] ref_buf_en_o,
  output logic [NUM_CH-1:0] channel_out_en_o,
  output logic [2:0] vco_div_sel_o,
  output logic vco_loop_open_o
);
  // The register map holds exactly four channel dividers
  if (NUM_CH != 4) begin : g_ch_check
    $error("NUM_CH must be 4");
  end

  // Lock detect count for a two-bit code
  function automatic logic [7:0] ld_count(input logic [1:0] code);
    unique case (code)
      2'b00: ld_count = phc_pkg::LD_COUNT_00;
      2'b01: ld_count = phc_pkg::LD_COUNT_01;
      2'b10: ld_count = phc_pkg::LD_COUNT_10;
      2'b11: ld_count = phc_pkg::LD_COUNT_11;
    endcase
  endfunction : ld_count

  // Shadow registers written by the host, active copies after update
  logic [7:0] sh_lock_cal, sh_ld_pin, sh_ref_sel, sh_hold, sh_vco_div;
  logic [7:0] ac_lock_cal, ac_ld_pin, ac_ref_sel, ac_hold, ac_vco_div;
  logic [7:0] sh_ch [NUM_CH];
  logic [7:0] ac_ch [NUM_CH];
  logic [7:0] status;
  logic [7:0] next_rdata;
  logic [NUM_CH-1:0] ch_sel;
  logic upd_wr;
  logic do_update;

  // Address decode
  assign ch_sel = {reg_addr_i == phc_pkg::ADDR_CH3, reg_addr_i == phc_pkg::ADDR_CH2,
                   reg_addr_i == phc_pkg::ADDR_CH1, reg_addr_i == phc_pkg::ADDR_CH0};
  assign upd_wr = reg_wr_i && (reg_addr_i == phc_pkg::ADDR_UPDATE);
  assign do_update = upd_wr && reg_wdata_i[phc_pkg::UPDATE_BIT];

  // Host writes into the shadow set
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sh_lock_cal <= phc_pkg::RST_VALUE;
      sh_ld_pin <= phc_pkg::RST_VALUE;
      sh_ref_sel <= phc_pkg::RST_VALUE;
      sh_hold <= phc_pkg::RST_VALUE;
      sh_vco_div <= phc_pkg::RST_VALUE;
      for (int i = 0; i < NUM_CH; i++) sh_ch[i] <= phc_pkg::RST_VALUE;
    end else if (reg_wr_i) begin
      if (reg_addr_i == phc_pkg::ADDR_LOCK_CAL) sh_lock_cal <= reg_wdata_i;
      if (reg_addr_i == phc_pkg::ADDR_LD_PIN) sh_ld_pin <= reg_wdata_i;
      if (reg_addr_i == phc_pkg::ADDR_REF_SEL) sh_ref_sel <= reg_wdata_i;
      if (reg_addr_i == phc_pkg::ADDR_HOLD) sh_hold <= reg_wdata_i;
      if (reg_addr_i == phc_pkg::ADDR_VCO_DIV) sh_vco_div <= reg_wdata_i;
      for (int i = 0; i < NUM_CH; i++) if (ch_sel[i]) sh_ch[i] <= reg_wdata_i;
    end
  end

  // Update strobe copies shadow to active; the strobe itself self-clears
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ac_lock_cal <= phc_pkg::RST_VALUE;
      ac_ld_pin <= phc_pkg::RST_VALUE;
      ac_ref_sel <= phc_pkg::RST_VALUE;
      ac_hold <= phc_pkg::RST_VALUE;
      ac_vco_div <= phc_pkg::RST_VALUE;
      for (int i = 0; i < NUM_CH; i++) ac_ch[i] <= phc_pkg::RST_VALUE;
    end else if (do_update) begin
      ac_lock_cal <= sh_lock_cal;
      ac_ld_pin <= sh_ld_pin;
      ac_ref_sel <= sh_ref_sel;
      ac_hold <= sh_hold;
      ac_vco_div <= sh_vco_div;
      for (int i = 0; i < NUM_CH; i++) ac_ch[i] <= sh_ch[i];
    end
  end

  // Calibration trigger: calibrate bit rising in the active copy
  phc_cal_if cal_link ();
  logic cal_trig;
  assign cal_trig = do_update && sh_lock_cal[phc_pkg::CAL_START_BIT]
                    && !ac_lock_cal[phc_pkg::CAL_START_BIT];
  assign cal_link.trigger = cal_trig;
  assign cal_link.div_sel = ac_lock_cal[phc_pkg::CAL_DIV_LSB +: 2];
  assign cal_link.pfd_tick = phase_detector_tick_i;

  phc_cal_seq #(
    .CAL_LEN(CAL_LEN)
  ) u_cal (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cal(cal_link.seq)
  );

  // Digital lock detector: consecutive in-window cycles
  logic [7:0] ld_cnt;
  logic digital_lock_indicator;
  logic dld_en;
  logic [7:0] ld_target;
  assign dld_en = !ac_lock_cal[phc_pkg::DLD_DISABLE_BIT];
  assign ld_target = ld_count(ac_lock_cal[phc_pkg::LD_COUNT_LSB +: 2]);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ld_cnt <= 8'h00;
      digital_lock_indicator <= 1'b0;
    end else if (!dld_en) begin
      ld_cnt <= 8'h00;
      digital_lock_indicator <= 1'b0;
    end else if (phase_detector_tick_i) begin
      if (!phase_detector_in_window_i) begin
        ld_cnt <= 8'h00;
        digital_lock_indicator <= 1'b0;
      end else if (ld_cnt != ld_target) begin
        ld_cnt <= ld_cnt + 8'h01;
        digital_lock_indicator <= (ld_cnt + 8'h01) == ld_target;
      end
    end
  end

  // Reference selection and monitored flags
  logic use_b;
  logic next_use_b;
  logic prefer_b;
  logic auto_sw;
  logic vco_mon_low;
  assign prefer_b = ac_ref_sel[phc_pkg::REF_PREFER_B_BIT];
  assign auto_sw = ac_ref_sel[phc_pkg::REF_AUTO_SW_BIT];
  assign next_use_b = !auto_sw ? prefer_b :
                      (prefer_b ? !(ref_input_b_low_i && !ref_input_a_low_i)
                                : (ref_input_a_low_i && !ref_input_b_low_i));
  assign vco_mon_low = clk_input_sel_i ? clk_input_low_i : vco_low_i;

  // Holdover control
  phc_pkg::phc_hold_state_t hstate;
  phc_pkg::phc_hold_state_t next_hstate;
  logic hold_en, hold_ext, comp_en;
  logic sync_n_q;
  logic sync_fall;
  logic ld_sensed;
  logic ref_edge;
  logic exit_hold;
  assign hold_en = ac_hold[phc_pkg::HOLD_EN_BIT];
  assign hold_ext = ac_hold[phc_pkg::HOLD_EXT_BIT];
  assign comp_en = ac_hold[phc_pkg::LD_COMP_EN_BIT];
  assign sync_fall = sync_n_q && !sync_n_i;
  assign ld_sensed = comp_en ? lock_detect_pin_i : 1'b1;
  assign ref_edge = use_b ? ref_input_b_edge_i : ref_input_a_edge_i;
  assign exit_hold = (hstate == phc_pkg::HS_HOLD) && ref_edge
                     && (!hold_ext || sync_n_i);

  // Next holdover state
  always_comb begin
    next_hstate = hstate;
    if (!hold_en) begin
      next_hstate = phc_pkg::HS_ARMED;
    end else begin
      unique case (hstate)
        phc_pkg::HS_ARMED: begin
          if (hold_ext ? sync_fall : !ld_sensed) next_hstate = phc_pkg::HS_HOLD;
        end
        phc_pkg::HS_HOLD: begin
          if (exit_hold) next_hstate = hold_ext ? phc_pkg::HS_ARMED : phc_pkg::HS_REARM;
        end
        phc_pkg::HS_REARM: begin
          if (hold_ext || ld_sensed) next_hstate = phc_pkg::HS_ARMED;
        end
        default: next_hstate = phc_pkg::HS_ARMED;
      endcase
    end
  end

  // Channel enable: off while sync low unless ignored, and during calibration
  logic [NUM_CH-1:0] next_ch_en;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      next_ch_en[i] = !cal_link.out_sync
                      && (sync_n_i || ac_ch[i][phc_pkg::CH_IGNORE_SYNC_BIT]);
    end
  end

  // Holdover state and charge pump controls
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hstate <= phc_pkg::HS_ARMED;
      sync_n_q <= 1'b1;
      use_b <= 1'b0;
      charge_pump_out_tristate_o <= 1'b0;
      b_counter_reset_o <= 1'b0;
    end else begin
      hstate <= next_hstate;
      sync_n_q <= sync_n_i;
      use_b <= next_use_b;
      charge_pump_out_tristate_o <= (next_hstate == phc_pkg::HS_HOLD);
      b_counter_reset_o <= exit_hold && hold_en;
    end
  end

  // Lock pin drives the current-source indicator only in its own mode
  logic ld_mode_cs;
  assign ld_mode_cs = (ac_ld_pin[5:0] == phc_pkg::LD_MODE_CURRENT_SRC);

  // Registered side outputs
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      digital_lock_indicator_o <= 1'b0;
      current_source_lock_indicator_o <= 1'b0;
      ref_use_b_o <= 1'b0;
      ref_buf_en_o <= 2'b00;
      channel_out_en_o <= '0;
      vco_div_sel_o <= 3'h0;
      vco_loop_open_o <= 1'b0;
    end else begin
      digital_lock_indicator_o <= digital_lock_indicator;
      current_source_lock_indicator_o <= digital_lock_indicator && ld_mode_cs;
      ref_use_b_o <= use_b;
      ref_buf_en_o <= ac_ref_sel[phc_pkg::REF_BUF_LSB +: 2];
      channel_out_en_o <= next_ch_en;
      vco_div_sel_o <= ac_vco_div[2:0];
      vco_loop_open_o <= cal_link.loop_open;
    end
  end

  // Status and read data
  always_comb begin
    status = 8'h00;
    status[phc_pkg::ST_DLD_BIT] = digital_lock_indicator;
    status[phc_pkg::ST_REF_A_LOW_BIT] = ref_input_a_low_i;
    status[phc_pkg::ST_REF_B_LOW_BIT] = ref_input_b_low_i;
    status[phc_pkg::ST_VCO_LOW_BIT] = vco_mon_low;
    status[phc_pkg::ST_HOLD_BIT] = charge_pump_out_tristate_o;
    status[phc_pkg::ST_CAL_DONE_BIT] = cal_link.done;
    next_rdata = 8'h00;
    unique case (reg_addr_i)
      phc_pkg::ADDR_LOCK_CAL: next_rdata = sh_lock_cal;
      phc_pkg::ADDR_LD_PIN: next_rdata = sh_ld_pin;
      phc_pkg::ADDR_REF_SEL: next_rdata = sh_ref_sel;
      phc_pkg::ADDR_HOLD: next_rdata = sh_hold;
      phc_pkg::ADDR_STATUS: next_rdata = status;
      phc_pkg::ADDR_CH0: next_rdata = sh_ch[0];
      phc_pkg::ADDR_CH1: next_rdata = sh_ch[1];
      phc_pkg::ADDR_CH2: next_rdata = sh_ch[2];
      phc_pkg::ADDR_CH3: next_rdata = sh_ch[3];
      phc_pkg::ADDR_VCO_DIV: next_rdata = sh_vco_div;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) reg_rdata_o <= 8'h00;
    else if (reg_rd_i) reg_rdata_o <= next_rdata;
  end

  hold_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !hold_en |=> !charge_pump_out_tristate_o)
    else $error("charge pump tri-stated with holdover disabled");
  manual_entry_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hold_en && hold_ext && hstate == phc_pkg::HS_ARMED && sync_fall
    |=> charge_pump_out_tristate_o)
    else $error("sync falling edge missed");
  manual_exit_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(charge_pump_out_tristate_o) && $past(hold_en) |-> $past(ref_edge))
    else $error("charge pump left tri-state without reference edge");
  b_reset_pair_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    b_counter_reset_o |-> $fell(charge_pump_out_tristate_o))
    else $error("B counter reset not with charge pump exit");
  auto_entry_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hold_en && !hold_ext && hstate == phc_pkg::HS_ARMED && comp_en
    && !lock_detect_pin_i |=> charge_pump_out_tristate_o)
    else $error("lock loss did not start holdover");
  comp_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !comp_en && !hold_ext && hstate == phc_pkg::HS_ARMED |=> !charge_pump_out_tristate_o)
    else $error("holdover entered with comparator disabled");
  rearm_block_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hstate == phc_pkg::HS_REARM && hold_en && !hold_ext && !ld_sensed
    |=> hstate == phc_pkg::HS_REARM)
    else $error("holdover rearmed before lock detect pin high");
  dld_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(digital_lock_indicator) |-> $past(ld_cnt) == ld_target - 8'h01)
    else $error("digital lock declared at wrong count");
  ch_sync_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !sync_n_i && !ac_ch[0][phc_pkg::CH_IGNORE_SYNC_BIT] |=> !channel_out_en_o[0])
    else $error("channel kept running while sync low");
  cs_lock_mode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    current_source_lock_indicator_o |-> $past(digital_lock_indicator) && $past(ld_mode_cs))
    else $error("current-source lock shown outside its pin mode");
endmodule : phc_ctrl

// ===== bench/phc_host_model.sv
// Host model driving the register port of the holdover and calibration block
`timescale 1ns/10ps
module phc_host_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [9:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  // Idle bus at time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 10'h000;
    reg_wdata_o = 8'h00;
  end
  // One-cycle write strobe, launched and dropped on falling edges
  task automatic wr(input logic [9:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    reg_wr_o = 1'b1;
    reg_addr_o = addr;
    reg_wdata_o = data;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
  endtask : wr
  // Read strobe; data taken once the registered answer has settled
  task automatic rd(input logic [9:0] addr, output logic [7:0] data);
    @(negedge clk_i);
    reg_rd_o = 1'b1;
    reg_addr_o = addr;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    @(negedge clk_i);
    data = reg_rdata_i;
  endtask : rd
  // Copy shadow settings into the active registers
  task automatic update();
    wr(phc_pkg::ADDR_UPDATE, 8'h01);
  endtask : update
  // Start a calibration; every one after the first needs a clear first
  task automatic calibrate(input logic [7:0] ctl, input logic first);
    if (!first) begin
      wr(phc_pkg::ADDR_LOCK_CAL, ctl & 8'hfe);
      update();
    end
    wr(phc_pkg::ADDR_LOCK_CAL, ctl | 8'h01);
    update();
  endtask : calibrate
endmodule : phc_host_model

// ===== bench/pll_holdover_and_vco_calibration_tb_top.sv
// Self-checking bench for holdover control and calibration sequencing
`timescale 1ns/10ps
module pll_holdover_and_vco_calibration_tb_top;
  localparam int CAL_SHORT = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr, rd, sync_n, ld_pin, ref_a, ref_b, tick_p, in_win, a_low, b_low, v_low, c_low, c_sel;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, d;
  logic tri_st, b_rst, digital_lock_indicator, csld, use_b, loop_open;
  logic [1:0] buf_en;
  logic [3:0] ch_en;
  logic [2:0] vdiv;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int b_resets = 0;
  int base;
  logic [9:0] rw_addr [9] = '{10'h018, 10'h01a, 10'h01c, 10'h01d, 10'h191, 10'h194, 10'h197,
    10'h19a, 10'h1e0};

  always #2 clk = ~clk;

  phc_host_model host_u (.clk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  phc_ctrl #(.NUM_CH(4), .CAL_LEN(CAL_SHORT)) dut_u (.clk_i(clk), .sys_rst_i(sys_rst),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .sync_n_i(sync_n), .lock_detect_pin_i(ld_pin), .ref_input_a_edge_i(ref_a),
    .ref_input_b_edge_i(ref_b), .phase_detector_tick_i(tick_p),
    .phase_detector_in_window_i(in_win), .ref_input_a_low_i(a_low), .ref_input_b_low_i(b_low),
    .vco_low_i(v_low), .clk_input_low_i(c_low), .clk_input_sel_i(c_sel),
    .charge_pump_out_tristate_o(tri_st), .b_counter_reset_o(b_rst),
    .digital_lock_indicator_o(digital_lock_indicator), .current_source_lock_indicator_o(csld),
    .ref_use_b_o(use_b), .ref_buf_en_o(buf_en), .channel_out_en_o(ch_en),
    .vco_div_sel_o(vdiv), .vco_loop_open_o(loop_open));

  // Cycle ceiling and count of B counter reset pulses
  always @(posedge clk) begin
    cycles++;
    if (b_rst === 1'b1)
      b_resets++;
    if (cycles == 6000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rd(input logic [9:0] a, input logic [7:0] exp);
    host_u.rd(a, d);
    chk("register", exp, d);
  endtask : chk_rd

  // Status read masked to monitor and calibration-done bits
  task automatic chk_st(input logic [7:0] exp);
    cyc(3);
    host_u.rd(phc_pkg::ADDR_STATUS, d);
    chk("status", exp, d & 8'h4e);
  endtask : chk_st

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // One reference phase detector edge on path A or B
  task automatic pulse(input logic on_b);
    @(negedge clk);
    ref_a = ~on_b;
    ref_b = on_b;
    @(negedge clk);
    ref_a = 1'b0;
    ref_b = 1'b0;
  endtask : pulse

  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk);
      tick_p = 1'b1;
      @(negedge clk);
      tick_p = 1'b0;
    end
  endtask : tick

  // Leave holdover on a path A edge and count one B counter reset
  task automatic exit_hold(input string what);
    base = b_resets;
    pulse(1'b0);
    cyc(2);
    chk(what, 8'h00, 8'(tri_st));
    chk("b reset", 8'h01, 8'(b_resets - base));
  endtask : exit_hold

  initial begin
    {sync_n, ld_pin} = 2'b11;
    {ref_a, ref_b, tick_p, in_win, a_low, b_low, v_low, c_low, c_sel} = '0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    // Reset values, read-only status, unmapped space, read back
    foreach (rw_addr[i]) chk_rd(rw_addr[i], phc_pkg::RST_VALUE);
    host_u.wr(phc_pkg::ADDR_STATUS, 8'hff);
    chk_rd(phc_pkg::ADDR_STATUS, 8'h00);
    chk_rd(10'h100, 8'h00);
    host_u.wr(phc_pkg::ADDR_UPDATE, 8'h5a);
    chk_rd(phc_pkg::ADDR_UPDATE, 8'h00);
    foreach (rw_addr[i]) begin
      host_u.wr(rw_addr[i], 8'h5a);
      chk_rd(rw_addr[i], 8'h5a);
      host_u.wr(rw_addr[i], 8'h00);
    end
    // Manual holdover, prefer A, channels 0 to 2 ignore the sync pin
    host_u.wr(phc_pkg::ADDR_REF_SEL, 8'h06);
    host_u.wr(phc_pkg::ADDR_HOLD, 8'h02);
    for (int c = 4; c < 7; c++) host_u.wr(rw_addr[c], 8'h40);
    host_u.update();
    cyc(2);
    chk("buffers", 8'h03, 8'(buf_en));
    chk("use b", 8'h00, 8'(use_b));
    sync_n = 1'b0;
    cyc(3);
    chk("hold disabled", 8'h00, 8'(tri_st));
    host_u.wr(phc_pkg::ADDR_HOLD, 8'h03);
    host_u.update();
    cyc(2);
    chk("level only", 8'h00, 8'(tri_st));
    sync_n = 1'b1;
    cyc(2);
    sync_n = 1'b0;
    cyc(2);
    chk("sync hold", 8'h01, 8'(tri_st));
    chk("chan off", 8'h07, 8'(ch_en));
    pulse(1'b0);
    chk("ref sync low", 8'h01, 8'(tri_st));
    sync_n = 1'b1;
    cyc(5);
    chk("no ref", 8'h01, 8'(tri_st));
    pulse(1'b1);
    cyc(2);
    chk("other ref", 8'h01, 8'(tri_st));
    exit_hold("manual exit");
    // Automatic holdover from the sensed lock pin
    host_u.wr(phc_pkg::ADDR_HOLD, 8'h09);
    host_u.update();
    ld_pin = 1'b0;
    cyc(2);
    chk("auto hold", 8'h01, 8'(tri_st));
    exit_hold("auto exit");
    cyc(4);
    chk("no reentry", 8'h00, 8'(tri_st));
    ld_pin = 1'b1;
    cyc(2);
    ld_pin = 1'b0;
    cyc(2);
    chk("reentry", 8'h01, 8'(tri_st));
    exit_hold("auto exit");
    host_u.wr(phc_pkg::ADDR_HOLD, 8'h01);
    host_u.update();
    cyc(4);
    chk("comparator off", 8'h00, 8'(tri_st));
    // Digital lock after five in-window cycles, pin mode, disable bit
    ld_pin = 1'b1;
    in_win = 1'b1;
    host_u.wr(phc_pkg::ADDR_LD_PIN, 8'h04);
    host_u.update();
    tick(4);
    cyc(2);
    chk("lock early", 8'h00, 8'(digital_lock_indicator));
    tick(1);
    cyc(2);
    chk("lock", 8'h01, 8'(digital_lock_indicator));
    chk("cs lock", 8'h01, 8'(csld));
    host_u.wr(phc_pkg::ADDR_LOCK_CAL, 8'h08);
    host_u.update();
    cyc(2);
    chk("lock off", 8'h00, 8'(digital_lock_indicator));
    host_u.wr(phc_pkg::ADDR_LOCK_CAL, 8'h00);
    // Monitors and automatic switchover away from a low reference
    a_low = 1'b1;
    host_u.wr(phc_pkg::ADDR_REF_SEL, 8'h16);
    host_u.update();
    cyc(2);
    chk("switch to b", 8'h01, 8'(use_b));
    chk_st(8'h02);
    b_low = 1'b1;
    chk_st(8'h06);
    {a_low, b_low, v_low} = 3'b001;
    chk_st(8'h08);
    c_sel = 1'b1;
    chk_st(8'h00);
    c_low = 1'b1;
    chk_st(8'h08);
    {v_low, c_low, c_sel} = 3'b000;
    // First calibration, then a clear-and-set one; divider 2 then 4
    host_u.wr(phc_pkg::ADDR_VCO_DIV, 8'h01);
    for (int k = 0; k < 2; k++) begin
      host_u.calibrate(8'(k << phc_pkg::CAL_DIV_LSB), k == 0);
      cyc(3);
      chk("loop open", 8'h01, 8'(loop_open));
      chk("outputs synced", 8'h00, 8'(ch_en));
      chk_st(8'h00);
      tick((2 << k) * CAL_SHORT - 2);
      chk("still open", 8'h01, 8'(loop_open));
      tick(2);
      for (int w = 0; w < 12 && loop_open === 1'b1; w++) cyc(1);
      chk("loop closed", 8'h00, 8'(loop_open));
      chk("outputs back", 8'h0f, 8'(ch_en));
      chk_st(8'h40);
    end
    chk("vco divider", 8'h01, 8'(vdiv));
    end_sim();
  end
endmodule : pll_holdover_and_vco_calibration_tb_top
